// ===== src/rf_id_defines.svh
// constants for the contactless family/format identifier command block
// assumes a 20 MHz system clock derived from the rf field
`ifndef RF_ID_DEFINES_SVH
`define RF_ID_DEFINES_SVH

// command codes
`define CMD_RESET_READY   8'h26
`define CMD_WRITE_FAMILY  8'h27
`define CMD_LOCK_FAMILY   8'h28
`define CMD_WRITE_FORMAT  8'h29
`define CMD_LOCK_FORMAT   8'h2a

// error codes
`define ERR_OPTION        8'h03
`define ERR_RELOCK        8'h11
`define ERR_LOCKED        8'h12
`define ERR_PROGRAM       8'h13
`define ERR_LOCK_FAIL     8'h14

// flag bit positions
`define REQ_FLAG_ADDRESS  5
`define REQ_FLAG_OPTION   6
`define RESP_FLAG_ERROR   0

// register offsets and fields
`define REG_CTRL          4'h0
`define REG_STATUS        4'h4
`define REG_UID_LO        4'h8
`define REG_UID_HI        4'hc
`define CTRL_WIP_MODE     0

// reset values
`define FAMILY_ID_RST     8'h00
`define FORMAT_ID_RST     8'h00
`define UID_RST           64'h0123_4567_89ab_cdef

// timing
`define CLK_PERIOD_NS     50
`define NOMINAL_RESPONSE_DELAY_NS          321000
`define PGM_PERIOD_NS     302000
`define PGM_PERIODS       18
`define PGM_TIME_NS       (`NOMINAL_RESPONSE_DELAY_NS + `PGM_PERIODS * `PGM_PERIOD_NS)
`define PGM_CYCLES \
    ((`PGM_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T1_CYCLES \
    ((`NOMINAL_RESPONSE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== src/rf_id_pkg.sv
// types shared by the identifier command block and its store
// assumes the defines header is compiled alongside
package rf_id_pkg;

    // command sequencer states
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_RX,
        ST_DELAY,
        ST_PROG,
        ST_POLL,
        ST_RESP
    } cmd_state_e;

    // nonvolatile operations
    typedef enum logic [1:0]
    {
        OP_WR_FAMILY,
        OP_LOCK_FAMILY,
        OP_WR_FORMAT,
        OP_LOCK_FORMAT
    } nvm_op_e;

endpackage : rf_id_pkg

// ===== src/rf_id_nvm.sv
// nonvolatile identifier store with its timed programming cycle
// assumes start is a one-cycle pulse only while busy is low
`include "rf_id_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module rf_id_nvm
    import rf_id_pkg::*;
#(
    parameter int unsigned PGM_CYCLES = `PGM_CYCLES
)
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire nvm_op_e    op,
    input  wire logic [7:0] wdata,
    input  wire logic       fault,
    output logic            busy,
    output logic            done,
    output logic            ok,
    output logic [7:0]      family_id,
    output logic [7:0]      format_id,
    output logic            family_lock,
    output logic            format_lock
);

    logic [19:0] cnt_ff;
    nvm_op_e     op_ff;
    logic [7:0]  data_ff;

    // program timer and latched operation
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            busy    <= 1'b0;
            done    <= 1'b0;
            cnt_ff  <= 20'h0;
            op_ff   <= OP_WR_FAMILY;
            data_ff <= 8'h00;
        end
        else
        begin
            done <= 1'b0;
            if (start && !busy)
            begin
                busy    <= 1'b1;
                cnt_ff  <= 20'(PGM_CYCLES - 1);
                op_ff   <= op;
                data_ff <= wdata;
            end
            else if (busy)
            begin
                if (cnt_ff == 20'h0)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                else
                begin
                    cnt_ff <= cnt_ff - 20'h1;
                end
            end
        end
    end

    // cell contents commit at the end of the cycle unless it faults
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ok          <= 1'b0;
            family_id   <= `FAMILY_ID_RST;
            format_id   <= `FORMAT_ID_RST;
            family_lock <= 1'b0;
            format_lock <= 1'b0;
        end
        else if (busy && cnt_ff == 20'h0)
        begin
            ok <= !fault;
            if (!fault)
            begin
                case (op_ff)
                    OP_WR_FAMILY:   family_id   <= data_ff;
                    OP_LOCK_FAMILY: family_lock <= 1'b1;
                    OP_WR_FORMAT:   format_id   <= data_ff;
                    OP_LOCK_FORMAT: format_lock <= 1'b1;
                    default:        ok          <= 1'b0;
                endcase
            end
        end
    end

endmodule : rf_id_nvm
`default_nettype wire

// ===== src/rf_family_format_id_cmds.sv
// reset to ready tail and family/format identifier write and lock
// assumes a framing layer that delivers decoded, crc-checked requests
// and sends the response frame it is handed, pulsing resp_done at its end
`include "rf_id_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module rf_family_format_id_cmds
    import rf_id_pkg::*;
#(
    parameter int unsigned PGM_CYCLES = `PGM_CYCLES,
    parameter int unsigned T1_CYCLES  = `T1_CYCLES
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire logic        req_sof,
    input  wire logic        req_valid,
    input  wire logic        req_bad,
    input  wire logic [7:0]  req_flags,
    input  wire logic [7:0]  req_cmd,
    input  wire logic [63:0] req_uid,
    input  wire logic [7:0]  req_id_value,
    input  wire logic        reader_eof,
    input  wire logic        resp_done,
    input  wire logic        leave_ready,
    input  wire logic        nvm_fault,
    input  wire logic        rf_activity_pin_in,
    output logic             rf_activity_pin_out,
    output logic             rf_activity_pin_oe,
    output logic             resp_valid,
    output logic [7:0]       resp_flags,
    output logic             resp_has_code,
    output logic [7:0]       resp_code,
    output logic             tag_ready
);

    // ******************************************************
    // decode helpers
    // ******************************************************

    // write or lock of either identifier
    function automatic logic is_id_cmd(input logic [7:0] cmd);
        is_id_cmd = (cmd == `CMD_WRITE_FAMILY) ||
                    (cmd == `CMD_LOCK_FAMILY)  ||
                    (cmd == `CMD_WRITE_FORMAT) ||
                    (cmd == `CMD_LOCK_FORMAT);
    endfunction : is_id_cmd

    // commands this block answers
    function automatic logic is_own_cmd(input logic [7:0] cmd);
        is_own_cmd = is_id_cmd(cmd) || (cmd == `CMD_RESET_READY);
    endfunction : is_own_cmd

    // ******************************************************
    // declarations
    // ******************************************************

    cmd_state_e  state_ff;
    cmd_state_e  nxt_state;
    logic        wip_mode_ff;
    logic [63:0] uid_ff;
    logic [16:0] cnt_ff;
    logic        opt_ff;
    logic        err_ff;
    logic [7:0]  code_ff;
    logic        addr_ok;
    logic        pre_err;
    logic [7:0]  pre_code;
    logic        nvm_start;
    nvm_op_e     nvm_op;
    logic        nvm_busy;
    logic        nvm_done;
    logic        nvm_ok;
    logic [7:0]  family_id;
    logic [7:0]  format_id;
    logic        family_lock;
    logic        format_lock;
    logic        take_req;
    logic        lock_op;

    // ******************************************************
    // request decode
    // ******************************************************

    // addressed requests must carry our uid, otherwise stay silent
    assign addr_ok = !req_flags[`REQ_FLAG_ADDRESS] ||
                     (req_uid == uid_ff);
    assign take_req = (state_ff == ST_RX) && req_valid &&
                      is_own_cmd(req_cmd) && addr_ok;

    // operation and lock check before any cycle starts
    always_comb
    begin
        nvm_op   = OP_WR_FAMILY;
        pre_err  = 1'b0;
        pre_code = 8'h00;
        lock_op  = 1'b0;
        case (req_cmd)
            `CMD_RESET_READY:
            begin
                pre_err  = req_flags[`REQ_FLAG_OPTION];
                pre_code = `ERR_OPTION;
            end
            `CMD_WRITE_FAMILY:
            begin
                nvm_op   = OP_WR_FAMILY;
                pre_err  = family_lock;
                pre_code = `ERR_LOCKED;
            end
            `CMD_LOCK_FAMILY:
            begin
                nvm_op   = OP_LOCK_FAMILY;
                lock_op  = 1'b1;
                pre_err  = family_lock;
                pre_code = `ERR_RELOCK;
            end
            `CMD_WRITE_FORMAT:
            begin
                nvm_op   = OP_WR_FORMAT;
                pre_err  = format_lock;
                pre_code = `ERR_LOCKED;
            end
            `CMD_LOCK_FORMAT:
            begin
                nvm_op   = OP_LOCK_FORMAT;
                lock_op  = 1'b1;
                pre_err  = format_lock;
                pre_code = `ERR_RELOCK;
            end
            default:
            begin
                pre_err  = 1'b0;
            end
        endcase
    end

    assign nvm_start = take_req && is_id_cmd(req_cmd) && !pre_err;

    // ******************************************************
    // command sequencer
    // ******************************************************

    // next state of the request/response sequence
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (req_sof)
                begin
                    nxt_state = ST_RX;
                end
            end
            ST_RX:
            begin
                if (req_bad)
                begin
                    nxt_state = ST_IDLE;
                end
                else if (req_valid)
                begin
                    if (!take_req)
                    begin
                        nxt_state = ST_IDLE;
                    end
                    else if (nvm_start)
                    begin
                        nxt_state = ST_PROG;
                    end
                    else
                    begin
                        nxt_state = ST_DELAY;
                    end
                end
            end
            ST_DELAY:
            begin
                if (cnt_ff == 17'h0)
                begin
                    nxt_state = ST_RESP;
                end
            end
            ST_PROG:
            begin
                // write time already holds the nominal response delay
                if (nvm_done)
                begin
                    nxt_state = opt_ff ? ST_POLL : ST_RESP;
                end
            end
            ST_POLL:
            begin
                if (reader_eof)
                begin
                    nxt_state = ST_RESP;
                end
            end
            ST_RESP:
            begin
                if (resp_done)
                begin
                    nxt_state = ST_IDLE;
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= ST_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // response delay counter
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cnt_ff <= 17'h0;
        end
        else if (take_req)
        begin
            cnt_ff <= 17'(T1_CYCLES - 1);
        end
        else if (cnt_ff != 17'h0)
        begin
            cnt_ff <= cnt_ff - 17'h1;
        end
    end

    // outcome of the current request
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            opt_ff    <= 1'b0;
            err_ff    <= 1'b0;
            code_ff   <= 8'h00;
        end
        else if (take_req)
        begin
            opt_ff    <= req_flags[`REQ_FLAG_OPTION];
            err_ff    <= pre_err;
            code_ff   <= pre_code;
        end
        else if (state_ff == ST_PROG && nvm_done && !nvm_ok)
        begin
            err_ff  <= 1'b1;
            code_ff <= lock_op ? `ERR_LOCK_FAIL : `ERR_PROGRAM;
        end
    end

    // lock_op must follow the latched command during programming
    // so req_cmd is held by the framing layer until the next sof

    // ******************************************************
    // response
    // ******************************************************

    // one-cycle response hand-off with flags and optional code
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            resp_valid    <= 1'b0;
            resp_flags    <= 8'h00;
            resp_has_code <= 1'b0;
            resp_code     <= 8'h00;
        end
        else
        begin
            resp_valid <= (state_ff != ST_RESP) && (nxt_state == ST_RESP);
            if ((state_ff != ST_RESP) && (nxt_state == ST_RESP))
            begin
                resp_flags <= 8'h00;
                resp_flags[`RESP_FLAG_ERROR] <= err_ff_next();
                resp_has_code <= err_ff_next();
                resp_code <= err_ff_next() ? code_next() : 8'h00;
            end
        end
    end

    // outcome including a fault reported in this very cycle
    function automatic logic err_ff_next();
        err_ff_next = err_ff ||
                      (state_ff == ST_PROG && nvm_done && !nvm_ok);
    endfunction : err_ff_next

    function automatic logic [7:0] code_next();
        if (state_ff == ST_PROG && nvm_done && !nvm_ok)
            code_next = lock_op ? `ERR_LOCK_FAIL : `ERR_PROGRAM;
        else
            code_next = code_ff;
    endfunction : code_next

    // tag state; return to ready wins over a leave in the same cycle
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            tag_ready <= 1'b1;
        end
        else if (take_req && req_cmd == `CMD_RESET_READY && !pre_err)
        begin
            tag_ready <= 1'b1;
        end
        else if (leave_ready)
        begin
            tag_ready <= 1'b0;
        end
    end

    // ******************************************************
    // activity pin
    // ******************************************************

    // busy mode: low from sof to response end; wip mode: low only
    // while the cell programs and until the response begins
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rf_activity_pin_oe  <= 1'b0;
            rf_activity_pin_out <= 1'b0;
        end
        else
        begin
            rf_activity_pin_out <= 1'b0;
            if (wip_mode_ff)
            begin
                rf_activity_pin_oe <= (nxt_state == ST_PROG) ||
                                      (nxt_state == ST_POLL);
            end
            else
            begin
                rf_activity_pin_oe <= (nxt_state != ST_IDLE);
            end
        end
    end

    // ******************************************************
    // nonvolatile store
    // ******************************************************

    rf_id_nvm #(
        .PGM_CYCLES  (PGM_CYCLES)
    ) u_nvm (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .start       (nvm_start),
        .op          (nvm_op),
        .wdata       (req_id_value),
        .fault       (nvm_fault),
        .busy        (nvm_busy),
        .done        (nvm_done),
        .ok          (nvm_ok),
        .family_id   (family_id),
        .format_id   (format_id),
        .family_lock (family_lock),
        .format_lock (format_lock)
    );

    // ******************************************************
    // register port
    // ******************************************************

    // software writes: mode and own uid
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wip_mode_ff <= 1'b0;
            uid_ff      <= `UID_RST;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `REG_CTRL)
            begin
                wip_mode_ff <= reg_wdata[`CTRL_WIP_MODE];
            end
            else if (reg_addr == `REG_UID_LO)
            begin
                uid_ff[31:0] <= reg_wdata;
            end
            else if (reg_addr == `REG_UID_HI)
            begin
                uid_ff[63:32] <= reg_wdata;
            end
        end
    end

    // read data the cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 32'h0;
        end
        else if (!reg_rd)
        begin
            reg_rdata <= 32'h0;
        end
        else if (reg_addr == `REG_CTRL)
        begin
            reg_rdata <= {31'h0, wip_mode_ff};
        end
        else if (reg_addr == `REG_STATUS)
        begin
            reg_rdata <= {11'h0, rf_activity_pin_in, nvm_busy, tag_ready,
                          format_lock, family_lock, format_id, family_id};
        end
        else if (reg_addr == `REG_UID_LO)
        begin
            reg_rdata <= uid_ff[31:0];
        end
        else if (reg_addr == `REG_UID_HI)
        begin
            reg_rdata <= uid_ff[63:32];
        end
        else
        begin
            reg_rdata <= 32'h0;
        end
    end

endmodule : rf_family_format_id_cmds
`default_nettype wire

// ===== dv/rf_reader_model.sv
// reader model: frames requests, polls after program time, ends replies
// assumes the tag marks each reply with a one-cycle resp_valid
`timescale 1ns/1ps
`default_nettype none

module rf_reader_model
#(
    parameter int WAIT_MAX = 80
)
(
    input  wire logic        clk_sys,
    input  wire logic        resp_valid,
    output logic             req_sof,
    output logic             req_valid,
    output logic             req_bad,
    output logic [7:0]       req_flags,
    output logic [7:0]       req_cmd,
    output logic [63:0]      req_uid,
    output logic [7:0]       req_id_value,
    output logic             reader_eof,
    output logic             resp_done
);
    // ****************************************
    // request framing and reply wait
    // ****************************************
    initial {req_sof, req_valid, req_bad, reader_eof, resp_done} = '0;
    initial {req_flags, req_cmd, req_uid, req_id_value} = '0;

    // fields held until the next frame; bad marks a broken frame
    task automatic send(input logic [7:0] fl, cm, input logic [63:0] u,
                        input logic [7:0] v, input logic bad,
                        input int eof_at, output logic got);
        got = 1'b0;
        @(posedge clk_sys);
        req_sof <= 1'b1;
        req_flags <= fl;
        req_cmd <= cm;
        req_uid <= u;
        req_id_value <= v;
        @(posedge clk_sys);
        req_sof <= 1'b0;
        repeat (4) @(posedge clk_sys);
        req_valid <= !bad;
        req_bad <= bad;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        req_bad <= 1'b0;
        // silent until the reply, apart from the end-of-frame poll
        for (int n = 0; n < WAIT_MAX && !got; n++)
        begin
            @(posedge clk_sys);
            reader_eof <= (n == eof_at);
            @(negedge clk_sys);
            got = resp_valid;
        end
        @(posedge clk_sys);
        reader_eof <= 1'b0;
        if (got)
        begin
            repeat (3) @(posedge clk_sys);
            resp_done <= 1'b1;
            @(posedge clk_sys);
            resp_done <= 1'b0;
        end
    endtask : send
endmodule : rf_reader_model
`default_nettype wire

// ===== dv/rf_family_format_id_cmds_chk.sv
// checker for reply framing and activity pin timing
// assumes it is bound into the identifier command block
`timescale 1ns/1ps
`default_nettype none

module rf_family_format_id_cmds_chk
    import rf_id_pkg::*;
#(
    parameter int unsigned T1_CYCLES = 8
)
(
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       req_sof,
    input wire logic       req_valid,
    input wire logic       req_bad,
    input wire logic [7:0] req_flags,
    input wire logic [7:0] req_cmd,
    input wire logic       resp_done,
    input wire logic       rf_activity_pin_out,
    input wire logic       rf_activity_pin_oe,
    input wire logic       resp_valid,
    input wire logic [7:0] resp_flags,
    input wire logic       resp_has_code,
    input wire logic [7:0] resp_code
);
    // ****************************************
    // properties
    // ****************************************
    localparam int T1_LO = T1_CYCLES;
    localparam int T1_HI = T1_CYCLES + 1;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // reply carrying a given code, none when zero
    sequence answer_s(logic [7:0] code);
        resp_valid && resp_code == code && resp_has_code == (code != 8'h00);
    endsequence
    // unaddressed reset to ready with the option bit given
    sequence ready_req_s(logic opt);
        req_valid && req_cmd == 8'h26 && req_flags[6:5] == {opt, 1'b0};
    endsequence

    reset_ready_a:
        assert property (ready_req_s(1'b0) |-> ##[T1_LO:T1_HI] answer_s(8'h00))
        else $error("reset to ready not answered cleanly");
    option_err_a:
        assert property (ready_req_s(1'b1) |-> ##[T1_LO:T1_HI] answer_s(8'h03))
        else $error("option error reply missing");
    err_bit_a:
        assert property (resp_valid |-> resp_flags == {7'h0, resp_has_code})
        else $error("error flag disagrees with code byte");
    code_absent_a:
        assert property (resp_valid && !resp_has_code |-> resp_code == 8'h00)
        else $error("code set without code byte");
    reply_pulse_a:
        assert property (resp_valid |=> !resp_valid)
        else $error("reply strobe longer than one cycle");
    pin_sink_a:
        assert property (rf_activity_pin_oe |-> !rf_activity_pin_out)
        else $error("activity pin driven high");
    pin_rise_a:
        assert property ($rose(rf_activity_pin_oe)
            |-> $past(req_sof) || $past(req_valid))
        else $error("activity pin pulled without a request");
    pin_fall_a:
        assert property ($fell(rf_activity_pin_oe) |-> resp_valid
            || $past(resp_done) || $past(req_valid) || $past(req_bad))
        else $error("activity pin released early");
endmodule : rf_family_format_id_cmds_chk

bind rf_family_format_id_cmds rf_family_format_id_cmds_chk
    #(.T1_CYCLES(T1_CYCLES)) chk (.*);
`default_nettype wire

// ===== dv/tb_rf_family_format_id_cmds.sv
// testbench for the identifier command block
// assumes the reader model and the checker are compiled before it
`include "rf_id_defines.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    num_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end

module tb_rf_family_format_id_cmds;
    import rf_id_pkg::*;
    // ****************************************
    // signals and instances
    // ****************************************
    localparam int PGM = 20;
    logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, leave_ready = 0;
    logic nvm_fault = 0, oe_seen, wip = 0, rdy = 1, lk_fam = 0, lk_fmt = 0;
    logic req_sof, req_valid, req_bad, reader_eof, resp_done, resp_valid;
    logic rf_activity_pin_in, rf_activity_pin_out, rf_activity_pin_oe;
    logic resp_has_code, tag_ready;
    logic [3:0]  reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata;
    logic [7:0]  req_flags, req_cmd, req_id_value, resp_flags, resp_code;
    logic [7:0]  fam = 0, fmt = 0;
    logic [63:0] req_uid, own = `UID_RST;
    logic [16:0] e, exp_q[$];
    int cycles = 0, num_errors = 0, checks_done = 0, seed = 32'h2444;

    assign rf_activity_pin_in = !rf_activity_pin_oe; // pull-up
    always #25 clk_sys = ~clk_sys;
    rf_reader_model rdr (.*);
    rf_family_format_id_cmds #(.PGM_CYCLES(PGM), .T1_CYCLES(8)) uut (.*);

    // hang guard and reply monitor
    always @(posedge clk_sys)
        if (++cycles == 10000)
        begin
            num_errors++;
            complete_run();
        end
    always @(negedge clk_sys)
    begin
        if (rf_activity_pin_oe) oe_seen = 1'b1;
        if (resp_valid)
        begin
            e = exp_q.size() ? exp_q.pop_front() : '1;
            `CHK("reply", e, {resp_flags, resp_has_code, resp_code})
        end
    end

    // ****************************************
    // tasks
    // ****************************************
    function automatic logic [31:0] status();
        return {11'h0, 1'b1, 1'b0, rdy, lk_fmt, lk_fam, fmt, fam};
    endfunction : status
    task automatic rd(input logic [3:0] a, input logic [31:0] x);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        `CHK("register", x, reg_rdata)
    endtask : rd
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    // one request; expected reply noted, pin use and store checked
    task automatic txn(input logic [7:0] fl, cm, v, code,
                       input logic [63:0] u, input logic bad, rsp);
        logic got;
        oe_seen = 1'b0;
        if (rsp) exp_q.push_back({7'h0, code != 0, code != 0, code});
        rdr.send(fl, cm, u, v, bad, fl[6] && cm != 8'h26 ? PGM + 6 : -1, got);
        `CHK("answered", rsp, got)
        `CHK("pin", wip ? rsp && cm != 8'h26 && !(code inside {8'h03, 8'h11,
            8'h12}) : 1'b1, oe_seen)
        if (rsp && code == 8'h00)
            case (cm)
                8'h26: rdy = 1'b1;
                8'h27: fam = v;
                8'h28: lk_fam = 1'b1;
                8'h29: fmt = v;
                8'h2a: lk_fmt = 1'b1;
                default: ;
            endcase
        `CHK("ready", rdy, tag_ready)
        rd(4'h4, status());
    endtask : txn
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(4'h0, 32'h0);
        rd(4'h8, own[31:0]);
        rd(4'hc, own[63:32]);
        rd(4'h2, 32'h0);
        wr(4'h4, '1);
        rd(4'h4, status());
        $display("test registers done");
        txn(8'h00, 8'h27, 8'($random(seed)), 8'h00, own, 0, 1);
        txn(8'h40, 8'h26, 8'h00, 8'h03, own, 0, 1);
        @(posedge clk_sys);
        leave_ready <= 1'b1;
        @(posedge clk_sys);
        leave_ready <= 1'b0;
        rdy = 1'b0;
        txn(8'h00, 8'h26, 8'h00, 8'h00, own, 0, 1);
        txn(8'h20, 8'h26, 8'h00, 8'h00, ~own, 0, 0);
        txn(8'h20, 8'h26, 8'h00, 8'h00, own, 0, 1);
        $display("test reset to ready done");
        txn(8'h00, 8'h28, 8'h00, 8'h00, own, 0, 1);
        txn(8'h40, 8'h27, 8'h5a, 8'h12, own, 0, 1);
        txn(8'h00, 8'h28, 8'h00, 8'h11, own, 0, 1);
        txn(8'h00, 8'h27, 8'h11, 8'h00, own, 1, 0);
        txn(8'h00, 8'h2b, 8'h00, 8'h00, own, 0, 0);
        $display("test family id done");
        txn(8'h00, 8'h29, 8'h3c, 8'h00, own, 0, 1);
        wr(4'h0, 32'h1);
        wip = 1'b1;
        rd(4'h0, 32'h1);
        txn(8'h00, 8'h26, 8'h00, 8'h00, own, 0, 1);
        txn(8'h40, 8'h29, 8'($random(seed)), 8'h00, own, 0, 1);
        @(posedge clk_sys);
        nvm_fault <= 1'b1;
        txn(8'h00, 8'h2a, 8'h00, 8'h14, own, 0, 1);
        txn(8'h00, 8'h29, fmt, 8'h13, own, 0, 1);
        @(posedge clk_sys);
        nvm_fault <= 1'b0;
        txn(8'h20, 8'h2a, 8'h00, 8'h00, own, 0, 1);
        txn(8'h00, 8'h29, 8'h77, 8'h12, own, 0, 1);
        txn(8'h00, 8'h2a, 8'h00, 8'h11, own, 0, 1);
        $display("test format id done");
        complete_run();
    end
endmodule : tb_rf_family_format_id_cmds
`default_nettype wire
